// ==== design/monitor_spi_slave_alert.sv ====
// Purpose: serial front end of a power monitor: strap-selected SPI slave with alert output
// Assumes: serial clock and chip select are slow pins sampled by clk_i (link period 80 ns or more)
// Notes: measurement core sits outside; it raises alert events and owns the other registers
// Functional notes
// - the interface-select strap is caught once after power-up reset and a high level selects SPI mode.
// - a low strap at power-up selects I2C mode and the SPI port stays silent.
// - in SPI mode the address strap works as an active-low chip select and the port acts only while it is low.
// - input bits are taken at rising serial clock edges and output bits change at falling edges.
// - all traffic is 8-bit bytes, most significant bit first, many bytes per frame.
// - command 0x00 then an address starts a write, and the next byte lands at that address.
// - the address pointer steps by one after each complete written byte.
// - a byte cut short by the end of the frame writes nothing.
// - command 0x01 then an address starts a read that shifts out registers from that address.
// - during a read the pointer steps after each byte sent, without limit, wrapping 0xFF to 0x00.
// - input data after the read address byte is ignored.
// - bit 0 of the alert master control register enables alerts and is set by reset.
// - each alert event has a mask bit in the eight mask registers and acts only when its bit is clear.
// - an enabled unmasked event pulls the alert output low and holds it until released.
// - reading the eight status registers clears them and so releases the alert output.
`timescale 1ns/100ps
module monitor_spi_slave_alert #(
  parameter int NREGS = spi_mon_pkg::NUM_ALERT_REGS
) (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic arst_n_i, // async reset, active low
  input wire logic interface_select_strap_i, // strap pin, high selects SPI
  input wire logic address_strap_chip_select_n_i, // chip select in SPI mode, active low
  input wire logic sclk_i, // serial clock pin
  input wire logic serial_input_pin_i, // serial data in
  output logic serial_output_pin_o, // serial data out
  output logic serial_output_pin_oe_o, // serial out driven
  output logic alert_n_o, // alert, active low
  output logic spi_mode_o, // 1: SPI mode latched
  input wire logic [NREGS*8-1:0] alert_event_i, // one-cycle event pulses from the core
  input wire logic [7:0] core_rd_data_i, // core register value at core_rd_addr_o
  output logic [7:0] core_rd_addr_o, // address of next byte to send
  output logic core_wr_valid_o, // write to a core register
  output logic [7:0] core_wr_addr_o, // core write address
  output logic [7:0] core_wr_data_o, // core write data
  input wire logic core_wr_ready_i // core accepts write
);
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;
  logic sclk_d_r;
  logic cs_n_d_r;
  logic strap_taken_r;
  logic spi_mode_r;
  logic [7:0] shift_in_r;
  logic [7:0] shift_out_r;
  logic [2:0] bit_cnt_r;
  spi_mon_pkg::phase_t phase_r;
  logic [7:0] ptr_r;
  logic [7:0] status_r [NREGS];
  logic [7:0] mask_r [NREGS];
  logic [7:0] master_ctrl_r;
  logic alert_n_r;
  logic miso_r;
  logic miso_oe_r;
  logic wr_valid_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_addr_r;
  logic rise;
  logic fall;
  logic active;
  logic frame_end;
  logic byte_done;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic load_rd;
  logic buf_in_ready;
  logic buf_out_valid;
  spi_mon_pkg::wr_req_t buf_in;
  spi_mon_pkg::wr_req_t buf_out;
  logic local_wr;
  logic any_alert;
  logic rd_addr_seen_r;
  logic cmd_bad_r;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    reg_idx = a[2:0];
  endfunction

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h1)
  ) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({serial_input_pin_i, sclk_i, address_strap_chip_select_n_i}),
    .q_o(pins_s)
  );
  assign cs_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[2];

  // strap is caught once, on the third clock after reset release, when the synchroniser
  // holds the real pin level instead of its reset value
  logic strap_s;
  pin_sync #(
    .WIDTH(1),
    .RESET_VAL(1'h0)
  ) u_strap_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(interface_select_strap_i),
    .q_o(strap_s)
  );
  logic [1:0] strap_wait_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_wait_r <= 2'h0;
      strap_taken_r <= 1'b0;
      spi_mode_r <= 1'b0;
    end else begin
      strap_wait_r <= {strap_wait_r[0], 1'b1};
      if (strap_wait_r[1] && !strap_taken_r) begin
        strap_taken_r <= 1'b1;
        spi_mode_r <= strap_s;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  assign active = spi_mode_r && !cs_n_s;
  assign rise = active && sclk_s && !sclk_d_r;
  assign fall = active && !sclk_s && sclk_d_r;
  assign frame_end = cs_n_s && !cs_n_d_r;
  assign byte_in = {shift_in_r[6:0], mosi_s};
  assign byte_done = rise && (bit_cnt_r == 3'h7);

  // local registers answer reads; everything else comes from the core
  always_comb begin
    if (in_range(ptr_r, spi_mon_pkg::ADDR_STATUS_FIRST, spi_mon_pkg::ADDR_STATUS_LAST)) begin
      rd_byte = status_r[reg_idx(ptr_r)];
    end else if (in_range(ptr_r, spi_mon_pkg::ADDR_MASK_FIRST, spi_mon_pkg::ADDR_MASK_LAST)) begin
      rd_byte = mask_r[reg_idx(ptr_r)];
    end else if (ptr_r == spi_mon_pkg::ADDR_MASTER_CTRL) begin
      rd_byte = master_ctrl_r;
    end else begin
      rd_byte = core_rd_data_i;
    end
  end

  // next byte is loaded on the fall that follows the last rise of a byte
  assign load_rd = fall && (bit_cnt_r == 3'h0) &&
                   (phase_r == spi_mon_pkg::PH_READ);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_r <= 3'h0;
      shift_in_r <= 8'h00;
      phase_r <= spi_mon_pkg::PH_CMD;
      ptr_r <= 8'h00;
    end else if (!active) begin
      bit_cnt_r <= 3'h0;
      phase_r <= spi_mon_pkg::PH_CMD;
    end else begin
      if (rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_in_r <= byte_in;
      end
      if (byte_done) begin
        case (phase_r)
          spi_mon_pkg::PH_CMD: begin
            if (cmd_bad_r) begin
              phase_r <= spi_mon_pkg::PH_CMD;
            end else if (byte_in == spi_mon_pkg::CMD_READ) begin
              phase_r <= spi_mon_pkg::PH_READ;
            end else if (byte_in == spi_mon_pkg::CMD_WRITE) begin
              phase_r <= spi_mon_pkg::PH_ADDR;
            end else begin
              phase_r <= spi_mon_pkg::PH_CMD;
            end
          end
          spi_mon_pkg::PH_ADDR: begin
            ptr_r <= byte_in;
            phase_r <= spi_mon_pkg::PH_WRITE;
          end
          spi_mon_pkg::PH_WRITE: begin
            ptr_r <= ptr_r + 8'h01;
          end
          default: begin
          end
        endcase
      end
      if (phase_r == spi_mon_pkg::PH_READ && byte_done && !rd_addr_seen_r) begin
        ptr_r <= byte_in;
      end
      if (load_rd && rd_addr_seen_r) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // read phase: first byte is the address, later input is ignored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_addr_seen_r <= 1'b0;
    end else if (!active || phase_r != spi_mon_pkg::PH_READ) begin
      rd_addr_seen_r <= 1'b0;
    end else if (byte_done) begin
      rd_addr_seen_r <= 1'b1;
    end
  end

  // an unknown command mutes the rest of the frame, so no later byte
  // can be mistaken for a command; only a new frame starts over
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_bad_r <= 1'b0;
    end else if (frame_end) begin
      cmd_bad_r <= 1'b0;
    end else if (byte_done && phase_r == spi_mon_pkg::PH_CMD && byte_in != spi_mon_pkg::CMD_READ &&
                 byte_in != spi_mon_pkg::CMD_WRITE) begin
      cmd_bad_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_out_r <= 8'h00;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= active;
      if (!active) begin
        miso_r <= 1'b0;
        shift_out_r <= 8'h00;
      end else if (load_rd && rd_addr_seen_r) begin
        miso_r <= rd_byte[7];
        shift_out_r <= {rd_byte[6:0], 1'b0};
      end else if (fall && bit_cnt_r != 3'h0) begin
        miso_r <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  // status addresses count as local, so a write there is dropped rather than sent to the core
  assign local_wr = in_range(ptr_r, spi_mon_pkg::ADDR_STATUS_FIRST, spi_mon_pkg::ADDR_MASK_LAST) ||
                    (ptr_r == spi_mon_pkg::ADDR_MASTER_CTRL);
  assign buf_in.addr = ptr_r;
  assign buf_in.data = byte_in;

  // core writes pass a two-entry buffer ahead of the output register; when full, the byte is dropped
  skid_buf2 #(
    .WIDTH(16)
  ) u_wr_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(byte_done && phase_r == spi_mon_pkg::PH_WRITE && !local_wr),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in),
    .out_valid_o(buf_out_valid),
    .out_ready_i(!wr_valid_r || core_wr_ready_i),
    .out_data_o(buf_out)
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_valid_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else if (!wr_valid_r || core_wr_ready_i) begin
      wr_valid_r <= buf_out_valid;
      wr_addr_r <= buf_out.addr;
      wr_data_r <= buf_out.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      master_ctrl_r <= spi_mon_pkg::MASTER_CTRL_RESET;
      for (int i = 0; i < NREGS; i++) begin
        mask_r[i] <= spi_mon_pkg::MASK_RESET;
      end
    end else if (byte_done && phase_r == spi_mon_pkg::PH_WRITE) begin
      if (ptr_r == spi_mon_pkg::ADDR_MASTER_CTRL) begin
        master_ctrl_r <= byte_in;
      end else if (in_range(ptr_r, spi_mon_pkg::ADDR_MASK_FIRST, spi_mon_pkg::ADDR_MASK_LAST)) begin
        mask_r[reg_idx(ptr_r)] <= byte_in;
      end
    end
  end

  // status bits are sticky; an event in the read cycle survives the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREGS; i++) begin
        status_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NREGS; i++) begin
        if (load_rd && rd_addr_seen_r && in_range(ptr_r, spi_mon_pkg::ADDR_STATUS_FIRST,
            spi_mon_pkg::ADDR_STATUS_LAST) && reg_idx(ptr_r) == 3'(i)) begin
          status_r[i] <= alert_event_i[i*8 +: 8];
        end else begin
          status_r[i] <= status_r[i] | alert_event_i[i*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    any_alert = 1'b0;
    for (int i = 0; i < NREGS; i++) begin
      any_alert = any_alert | (|(status_r[i] & ~mask_r[i]));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= !(master_ctrl_r[spi_mon_pkg::MASTER_EN_BIT] && any_alert);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_addr_r <= 8'h00;
    end else begin
      rd_addr_r <= ptr_r;
    end
  end

  assign serial_output_pin_o = miso_r;
  assign serial_output_pin_oe_o = miso_oe_r;
  assign alert_n_o = alert_n_r;
  assign spi_mode_o = spi_mode_r;
  assign core_rd_addr_o = rd_addr_r;
  assign core_wr_valid_o = wr_valid_r;
  assign core_wr_addr_o = wr_addr_r;
  assign core_wr_data_o = wr_data_r;
endmodule

// ==== design/pin_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes: reset value is a parameter so idle-high pins read idle
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [WIDTH-1:0] d_i, // raw pins
  output logic [WIDTH-1:0] q_o // synchronised pins
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ==== design/skid_buf2.sv ====
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock
// Notes: ready on the fill side drops only when both entries hold data
`timescale 1ns/100ps
module skid_buf2 #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i, // system clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic in_valid_i, // word offered
  output logic in_ready_o, // room for a word
  input wire logic [WIDTH-1:0] in_data_i, // offered word
  output logic out_valid_o, // word available
  input wire logic out_ready_i, // drain accepts word
  output logic [WIDTH-1:0] out_data_o // oldest word
);
  logic [WIDTH-1:0] mem_r [2];
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wr_ptr_r <= 1'b0;
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
      wr_ptr_r <= ~wr_ptr_r;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== design/spi_mon_pkg.sv ====
// Purpose: shared constants and types for the monitor serial front end
// Assumes: one 8-bit register space of 256 addresses
// Notes: offsets are byte addresses of the serial register space
package spi_mon_pkg;
  localparam logic [7:0] CMD_WRITE = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h80;
  localparam logic [7:0] ADDR_STATUS_LAST = 8'h87;
  localparam logic [7:0] ADDR_MASK_FIRST = 8'h88;
  localparam logic [7:0] ADDR_MASK_LAST = 8'h8F;
  localparam logic [7:0] ADDR_MASTER_CTRL = 8'hE8;
  localparam int MASTER_EN_BIT = 0;
  localparam logic [7:0] MASTER_CTRL_RESET = 8'h01;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam int NUM_ALERT_REGS = 8;
  localparam int BYTE_BITS = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_MIN_NS = 80;
  localparam int LINK_PERIOD_CYC = (LINK_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ = 2'b11
  } phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_t;
endpackage

// ==== sim/mon_spi_props.sv ====
// Purpose: port-level checks of the monitor serial front end
// Assumes: serial pins are slow against clk_i
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
module mon_spi_props #(
  parameter int NREGS = 8
) (
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic interface_select_strap_i, // strap
  input wire logic address_strap_chip_select_n_i, // chip select
  input wire logic sclk_i, // serial clock
  input wire logic serial_output_pin_o, // miso
  input wire logic serial_output_pin_oe_o, // miso enable
  input wire logic alert_n_o, // alert
  input wire logic spi_mode_o, // mode
  input wire logic [NREGS*8-1:0] alert_event_i, // events
  input wire logic core_wr_valid_o, // write valid
  input wire logic [7:0] core_wr_addr_o, // write address
  input wire logic [7:0] core_wr_data_o, // write data
  input wire logic core_wr_ready_i // write ready
);
  // saturating age of the last event pulse
  logic [3:0] since_ev_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      since_ev_r <= 4'hF;
    end else if (|alert_event_i) begin
      since_ev_r <= 4'h0;
    end else if (since_ev_r != 4'hF) begin
      since_ev_r <= since_ev_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence cs_idle_s;
    address_strap_chip_select_n_i [*6];
  endsequence
  sequence alert_idle_s;
    (!alert_n_o && address_strap_chip_select_n_i) [*8];
  endsequence
  AST_IDLE_QUIET: assert property (cs_idle_s |-> !serial_output_pin_oe_o && !serial_output_pin_o)
    else $error("miso active outside a frame");
  AST_NO_MODE_QUIET: assert property (!spi_mode_o |-> !serial_output_pin_oe_o)
    else $error("miso driven while not in spi mode");
  AST_MODE_FROM_STRAP: assert property ($rose(spi_mode_o) |-> interface_select_strap_i)
    else $error("spi mode set with strap low");
  AST_MODE_KEPT: assert property (spi_mode_o |=> spi_mode_o)
    else $error("spi mode lost");
  AST_MISO_AFTER_FALL: assert property ($changed(serial_output_pin_o) |-> !$past(sclk_i) && !$past(sclk_i, 2))
    else $error("miso changed away from a falling sclk");
  AST_ALERT_CAUSE: assert property ($fell(alert_n_o) |-> since_ev_r <= 4'h3)
    else $error("alert fell with no recent event");
  AST_ALERT_HELD: assert property (alert_idle_s |=> !alert_n_o)
    else $error("alert released outside a frame");
  AST_ALERT_RELEASE: assert property ($rose(alert_n_o) |-> serial_output_pin_oe_o)
    else $error("alert released without a serial access");
  AST_WR_NOT_LOCAL: assert property (core_wr_valid_o |-> core_wr_addr_o != 8'hE8 && core_wr_addr_o[7:4] != 4'h8)
    else $error("local register sent to the core");
  AST_WR_HOLD: assert property (core_wr_valid_o && !core_wr_ready_i |=> core_wr_valid_o && $stable(core_wr_data_o))
    else $error("stalled core write changed");
endmodule
bind monitor_spi_slave_alert mon_spi_props #(.NREGS(NREGS)) props (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .interface_select_strap_i(interface_select_strap_i), .sclk_i(sclk_i),
  .address_strap_chip_select_n_i(address_strap_chip_select_n_i), .serial_output_pin_o(serial_output_pin_o),
  .serial_output_pin_oe_o(serial_output_pin_oe_o), .alert_n_o(alert_n_o), .spi_mode_o(spi_mode_o),
  .alert_event_i(alert_event_i), .core_wr_valid_o(core_wr_valid_o), .core_wr_addr_o(core_wr_addr_o),
  .core_wr_data_o(core_wr_data_o), .core_wr_ready_i(core_wr_ready_i));

// ==== sim/monitor_spi_slave_alert_tb_top.sv ====
// Purpose: self-checking bench of the monitor serial front end
// Assumes: core read data is the inverse of its address
// Notes: serial traffic comes from spi_host_model
`timescale 1ns/100ps
module monitor_spi_slave_alert_tb_top;
  logic clk_i, arst_n_i, strap, ready, sclk, cs_n, mosi, miso_pin, miso_oe, alert_n, spi_mode, wr_valid;
  logic [63:0] events;
  logic [7:0] rd_addr, wr_addr, wr_data;
  logic [7:0] rb [8];
  logic [7:0] wd [2];
  logic [15:0] wq [$];
  wire logic miso_w;
  int errors, checks_done;
  assign miso_w = miso_oe ? miso_pin : 1'b1; // pull-up on the released line
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  monitor_spi_slave_alert dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .interface_select_strap_i(strap),
    .address_strap_chip_select_n_i(cs_n), .sclk_i(sclk), .serial_input_pin_i(mosi),
    .serial_output_pin_o(miso_pin), .serial_output_pin_oe_o(miso_oe), .alert_n_o(alert_n),
    .spi_mode_o(spi_mode), .alert_event_i(events), .core_rd_data_i(~rd_addr), .core_rd_addr_o(rd_addr),
    .core_wr_valid_o(wr_valid), .core_wr_addr_o(wr_addr), .core_wr_data_o(wr_data), .core_wr_ready_i(ready));
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
  always @(posedge clk_i) begin
    if (wr_valid && ready) begin
      wq.push_back({wr_addr, wr_data});
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one frame: command, address, n bytes, then an optional cut-short byte
  task automatic sess(input logic [7:0] cmd, input logic [7:0] a, input int n, input int tail);
    logic [7:0] rx;
    @(posedge clk_i);
    host.open_frame();
    host.xfer(cmd, 8, rx);
    host.xfer(a, 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xfer(cmd == spi_mon_pkg::CMD_READ ? 8'hA5 : wd[i], 8, rb[i]);
    end
    if (tail > 0) begin
      host.xfer(8'h3C, tail, rx);
    end
    host.close_frame();
  endtask
  task automatic pulse(input int idx);
    @(posedge clk_i);
    events <= 64'h1 << idx;
    @(posedge clk_i);
    events <= 64'h0;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic wait_alert(input logic lvl);
    for (int k = 0; k < 50 && alert_n !== lvl; k++) begin
      @(posedge clk_i);
    end
    chk({7'h0, alert_n}, {7'h0, lvl});
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    strap <= s;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    arst_n_i = 1'b0;
    strap = 1'b1;
    events = '0;
    ready = 1'b1;
    do_reset(1'b1);
    chk({7'h0, spi_mode}, 8'h01);
    sess(spi_mon_pkg::CMD_READ, 8'hE8, 2, 0);
    chk(rb[0], 8'h01);
    chk(rb[1], 8'h16);
    pulse(3);
    wait_alert(1'b1);
    sess(spi_mon_pkg::CMD_READ, 8'h80, 8, 0);
    wd[0] = 8'hF7;
    sess(spi_mon_pkg::CMD_WRITE, 8'h88, 1, 0);
    sess(spi_mon_pkg::CMD_READ, 8'h88, 1, 0);
    chk(rb[0], 8'hF7);
    pulse(3);
    wait_alert(1'b0);
    repeat (40) @(posedge clk_i);
    wait_alert(1'b0);
    sess(spi_mon_pkg::CMD_READ, 8'h80, 8, 0);
    for (int i = 0; i < 8; i++) begin
      chk(rb[i], i == 0 ? 8'h08 : 8'h00);
    end
    wait_alert(1'b1);
    wd[0] = 8'h00;
    sess(spi_mon_pkg::CMD_WRITE, 8'hE8, 1, 0);
    pulse(3);
    wait_alert(1'b1);
    sess(spi_mon_pkg::CMD_READ, 8'h80, 8, 0);
    wd[0] = 8'h01;
    sess(spi_mon_pkg::CMD_WRITE, 8'hE8, 1, 0);
    wd[0] = 8'h5A;
    wd[1] = 8'hC3;
    sess(spi_mon_pkg::CMD_WRITE, 8'h8E, 2, 4);
    sess(spi_mon_pkg::CMD_READ, 8'h8E, 2, 0);
    chk(rb[0], 8'h5A);
    chk(rb[1], 8'hC3);
    chk(8'(wq.size()), 8'h00);
    sess(spi_mon_pkg::CMD_READ, 8'hFF, 2, 0);
    chk(rb[0], 8'h00);
    chk(rb[1], 8'hFF);
    wd[0] = 8'h88;
    sess(8'h02, 8'h00, 2, 0);
    sess(spi_mon_pkg::CMD_READ, 8'h88, 1, 0);
    chk(rb[0], 8'hF7);
    ready <= 1'b0;
    wd[0] = 8'h11;
    wd[1] = 8'h22;
    sess(spi_mon_pkg::CMD_WRITE, 8'h10, 2, 0);
    chk(8'(wq.size()), 8'h00);
    ready <= 1'b1;
    repeat (10) @(posedge clk_i);
    for (int i = 0; i < 2; i++) begin
      chk(wq[i][15:8], 8'h10 + 8'(i));
      chk(wq[i][7:0], wd[i]);
    end
    do_reset(1'b0);
    chk({7'h0, spi_mode}, 8'h00);
    sess(spi_mon_pkg::CMD_READ, 8'hE8, 1, 0);
    chk(rb[0], 8'hFF);
    do_reset(1'b1);
    strap <= 1'b0;
    sess(spi_mon_pkg::CMD_READ, 8'hE8, 1, 0);
    chk(rb[0], 8'h01);
    conclude();
  end
endmodule

// ==== sim/spi_host_model.sv ====
// Purpose: behavioural spi master for the monitor serial port
// Assumes: mode 0, 80 ns serial period
// Notes: clock stands low between frames; bench calls the tasks
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk_o, // serial clock
  output logic cs_n_o, // chip select, active low
  output logic mosi_o, // data to device
  input wire logic miso_i // data from device
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // the 3 ns offset keeps pin edges off the system clock edge
  task automatic open_frame();
    #3 cs_n_o = 1'b0;
    #200;
  endtask
  task automatic close_frame();
    #100 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line shows no stale bit
    #200;
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi_o = tx[i];
      #40 rx = {rx[6:0], miso_i};
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
  endtask
endmodule
